/* File: ccdiv_pkg.sv */
/*
 * package for the channel clock divider: register offsets, field
 * positions, reset values, source-select codes and the divider states.
 * assumes the register port carries the printed register offsets as
 * plain addresses, eight data bits wide.
 */
package ccdiv_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W            = 10;
    localparam int          DATA_W            = 8;
    localparam logic [9:0]  OFS_CYCLE_COUNTS  = 10'h190;
    localparam logic [9:0]  OFS_CONTROL       = 10'h191;
    localparam logic [9:0]  OFS_ROUTING       = 10'h192;
    localparam logic [9:0]  OFS_STATUS        = 10'h1F0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CYCLE_COUNTS  = 8'h00;
    localparam logic [7:0]  RST_CONTROL       = 8'h80;
    localparam logic [7:0]  RST_ROUTING       = 8'h00;
    localparam logic [7:0]  RD_ZERO           = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          LOW_CNT_MSB       = 7;
    localparam int          LOW_CNT_LSB       = 4;
    localparam int          HIGH_CNT_MSB      = 3;
    localparam int          HIGH_CNT_LSB      = 0;
    localparam int          CNT_W             = 4;
    localparam int          BIT_BYPASS        = 7;
    localparam int          BIT_NOSYNC        = 6;
    localparam int          BIT_FORCE_HIGH    = 5;
    localparam int          BIT_START_HIGH    = 4;
    localparam int          PHASE_MSB         = 3;
    localparam int          PHASE_LSB         = 0;
    localparam int          BIT_DIRECT_OUT    = 1;
    localparam int          BIT_DCC_OFF       = 0;
    localparam int          ROUTING_MASK_W    = 2;

    // ----------------------------------------------------------------
    // source select codes for the direct route
    // ----------------------------------------------------------------
    localparam logic [1:0]  SRC_SEL_EXT_CLK   = 2'b00;
    localparam logic [1:0]  SRC_SEL_NONE      = 2'b01;
    localparam logic [1:0]  SRC_SEL_VCO       = 2'b10;

    // ----------------------------------------------------------------
    // divider states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_BYPASS = 5'b0_0001,
        ST_HOLD   = 5'b0_0010,
        ST_DELAY  = 5'b0_0100,
        ST_LOW    = 5'b0_1000,
        ST_HIGH   = 5'b1_0000
    } ccdiv_state_t;

    localparam int          STATE_W           = 5;
    localparam logic [3:0]  CNT_ONE           = 4'h1;
    localparam logic [3:0]  CNT_ZERO          = 4'h0;

endpackage : ccdiv_pkg

/* File: ccdiv_sync.sv */
/*
 * two flip-flop synchroniser for one level coming from a pin.
 * assumes the destination logic runs on mclk only.
 */
`timescale 1ns/1ps
`default_nettype none
module ccdiv_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output logic      level_out
);

    logic meta_ff;

    // ------------------------------------------------------------
    // two stages; only the second stage is ever read
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff   <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            meta_ff   <= pin_in;
            level_out <= meta_ff;
        end
    end

endmodule : ccdiv_sync
`default_nettype wire

/* File: ccdiv_regs.sv */
/*
 * register file of the channel clock divider: cycle counts, control,
 * routing, and a read-only status view of the divider.
 * assumes a master that issues one-cycle strobes, never both at once;
 * read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module ccdiv_regs
    import ccdiv_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [DATA_W-1:0]  status_in,
    output logic      [DATA_W-1:0]  cycle_counts_ff,
    output logic      [DATA_W-1:0]  control_ff,
    output logic      [DATA_W-1:0]  routing_ff,
    output logic      [DATA_W-1:0]  reg_rdata_ff
);

    logic [DATA_W-1:0] nxt_rdata;

    // ------------------------------------------------------------
    // writes
    // ------------------------------------------------------------
    // RULE4: bypass set, counts zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cycle_counts_ff <= RST_CYCLE_COUNTS;
            control_ff      <= RST_CONTROL;
            routing_ff      <= RST_ROUTING;
        end else if (reg_wr) begin
            if (reg_addr == OFS_CYCLE_COUNTS) begin
                cycle_counts_ff <= reg_wdata;
            end
            if (reg_addr == OFS_CONTROL) begin
                control_ff <= reg_wdata;
            end
            // only the direct-route and duty bits exist here
            if (reg_addr == OFS_ROUTING) begin
                routing_ff <= {{(DATA_W-ROUTING_MASK_W){1'b0}},
                               reg_wdata[ROUTING_MASK_W-1:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // read mux; unmapped addresses read zero
    // ------------------------------------------------------------
    always_comb begin
        unique case (reg_addr)
            OFS_CYCLE_COUNTS: nxt_rdata = cycle_counts_ff;
            OFS_CONTROL:      nxt_rdata = control_ff;
            OFS_ROUTING:      nxt_rdata = routing_ff;
            OFS_STATUS:       nxt_rdata = status_in;
            default:          nxt_rdata = RD_ZERO;
        endcase
    end

    // data stand one cycle only, zero otherwise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_ff <= RD_ZERO;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= RD_ZERO;
        end
    end

endmodule : ccdiv_regs
`default_nettype wire

/* File: ccdiv_top.sv */
/*
 * channel clock divider: programmable low/high cycle counts, bypass,
 * chip-level sync obedience, static forcing, start level, coarse phase
 * offset and a direct route of the source to the output pair.
 * assumes the divider input and the direct sources arrive as levels
 * sampled on mclk (mclk at least twice their rate); the sync pin is
 * asynchronous and active low.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: the output stays low for the upper-nibble count plus one input cycles.
// RULE2: the output stays high for the lower-nibble count plus one input cycles.
// RULE3: with bypass set the divider stops and the input clock passes through.
// RULE4: after reset bypass is one and both cycle counts are zero.
// RULE5: with ignore-sync clear the divider obeys chip sync, set it ignores it.
// RULE6: the force bit sets a static output level only while ignore-sync is set.
// RULE7: with bypass set the force bit has no effect.
// RULE8: the force bit resets to zero, so no high level is forced after reset.
// RULE9: the start bit picks the phase the output starts in on each (re)start.
// RULE10: the start bit resets to zero, a start in the low phase.
// RULE11: a four-bit phase offset delays the start, and resets to zero.
// RULE12: the direct bit routes the selected source straight to the output pair.
// RULE13: the divided period is the low plus the high duration.
// RULE14: an obeyed sync holds the start level and restarts counting on release.
module ccdiv_top
    import ccdiv_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    input  wire logic               sync_n,
    input  wire logic [1:0]         src_sel,
    input  wire logic               src_clk_lvl,
    input  wire logic               vco_lvl,
    input  wire logic               ext_clk_lvl,
    output logic                    first_output_a,
    output logic                    first_output_b
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0]  cycle_counts_ff;
    logic [DATA_W-1:0]  control_ff;
    logic [DATA_W-1:0]  routing_ff;
    logic [DATA_W-1:0]  status_w;
    logic               sync_n_s;
    logic               src_prev_ff;
    logic               src_rise;
    logic [CNT_W-1:0]   low_cnt;
    logic [CNT_W-1:0]   high_cnt;
    logic [CNT_W-1:0]   phase_ofs;
    logic               bypass_bit;
    logic               nosync_bit;
    logic               force_bit;
    logic               start_bit;
    logic               direct_bit;
    logic               hold_req;
    logic               force_act;
    logic               dir_active;
    logic               dir_lvl;
    logic               div_lvl;
    logic               nxt_out;
    ccdiv_state_t       state_ff;
    ccdiv_state_t       nxt_state;
    ccdiv_state_t       start_state;
    logic [CNT_W-1:0]   cnt_ff;
    logic [CNT_W-1:0]   nxt_cnt;
    logic               out_a_ff;
    logic               out_b_ff;

    // ------------------------------------------------------------
    // registers and pin synchroniser
    // ------------------------------------------------------------
    ccdiv_regs u_regs (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .status_in       (status_w),
        .cycle_counts_ff (cycle_counts_ff),
        .control_ff      (control_ff),
        .routing_ff      (routing_ff),
        .reg_rdata_ff    (reg_rdata)
    );

    // sync idles high, so the chain resets high to avoid a false hold
    ccdiv_sync #(.RST_VAL(1'b1)) u_sync (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .pin_in    (sync_n),
        .level_out (sync_n_s)
    );

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign low_cnt    = cycle_counts_ff[LOW_CNT_MSB:LOW_CNT_LSB];
    assign high_cnt   = cycle_counts_ff[HIGH_CNT_MSB:HIGH_CNT_LSB];
    assign phase_ofs  = control_ff[PHASE_MSB:PHASE_LSB];
    assign bypass_bit = control_ff[BIT_BYPASS];
    assign nosync_bit = control_ff[BIT_NOSYNC];
    assign force_bit  = control_ff[BIT_FORCE_HIGH];
    // RULE10: start bit zero after reset gives a low start
    assign start_bit  = control_ff[BIT_START_HIGH];
    assign direct_bit = routing_ff[BIT_DIRECT_OUT];
    assign status_w   = {state_ff, cnt_ff[CNT_W-2:0]};
    assign src_rise   = src_clk_lvl & ~src_prev_ff;

    // RULE5: sync obeyed only with ignore-sync clear
    assign hold_req   = ~sync_n_s & ~nosync_bit;
    // RULE6: forcing needs ignore-sync as well
    // RULE7: and bypass masks it
    assign force_act  = force_bit & nosync_bit & ~bypass_bit;
    // RULE9: first phase after a (re)start follows the start bit
    assign start_state = start_bit ? ST_HIGH : ST_LOW;

    // edge detect of the divider input; one cycle of latency is fine
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            src_prev_ff <= 1'b0;
        end else begin
            src_prev_ff <= src_clk_lvl;
        end
    end

    // ------------------------------------------------------------
    // divider state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        // RULE3: bypass wins over everything, divider parked
        if (bypass_bit) begin
            nxt_state = ST_BYPASS;
            nxt_cnt   = CNT_ZERO;
        // RULE14: obeyed sync holds and clears the count
        end else if (hold_req) begin
            nxt_state = ST_HOLD;
            nxt_cnt   = CNT_ZERO;
        end else begin
            unique case (state_ff)
                ST_BYPASS, ST_HOLD: begin
                    // RULE11: nonzero offset delays the first phase
                    nxt_state = (phase_ofs == CNT_ZERO) ? start_state : ST_DELAY;
                    nxt_cnt   = CNT_ZERO;
                end
                ST_DELAY: begin
                    if (src_rise) begin
                        if (cnt_ff == phase_ofs - CNT_ONE) begin
                            nxt_state = start_state;
                            nxt_cnt   = CNT_ZERO;
                        end else begin
                            nxt_cnt = cnt_ff + CNT_ONE;
                        end
                    end
                end
                // RULE1: low lasts low count plus one rises
                // RULE13: period is the two phases back to back
                ST_LOW: begin
                    if (src_rise) begin
                        if (cnt_ff == low_cnt) begin
                            nxt_state = ST_HIGH;
                            nxt_cnt   = CNT_ZERO;
                        end else begin
                            nxt_cnt = cnt_ff + CNT_ONE;
                        end
                    end
                end
                // RULE2: high lasts high count plus one rises
                ST_HIGH: begin
                    if (src_rise) begin
                        if (cnt_ff == high_cnt) begin
                            nxt_state = ST_LOW;
                            nxt_cnt   = CNT_ZERO;
                        end else begin
                            nxt_cnt = cnt_ff + CNT_ONE;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_HOLD;
                    nxt_cnt   = CNT_ZERO;
                end
            endcase
        end
    end

    // state and count registers; reset lands in bypass like the control
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_BYPASS;
            cnt_ff   <= CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // output level selection
    // ------------------------------------------------------------
    always_comb begin
        unique case (state_ff)
            ST_BYPASS:         div_lvl = src_clk_lvl;
            ST_HOLD, ST_DELAY: div_lvl = start_bit;
            ST_LOW:            div_lvl = 1'b0;
            ST_HIGH:           div_lvl = 1'b1;
            default:           div_lvl = 1'b0;
        endcase
    end

    // RULE12: direct route picks vco or external clock, code 01 is a no-op
    assign dir_active = direct_bit & (src_sel != SRC_SEL_NONE) &
                        (src_sel == SRC_SEL_VCO || src_sel == SRC_SEL_EXT_CLK);
    assign dir_lvl    = (src_sel == SRC_SEL_VCO) ? vco_lvl : ext_clk_lvl;

    // RULE6: static level replaces the divided clock while forced
    // RULE8: force bit resets low, so nothing is forced high after reset
    assign nxt_out = dir_active ? dir_lvl :
                     force_act  ? force_bit : div_lvl;

    // output pair, complementary, both straight from flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b1;
        end else begin
            out_a_ff <= nxt_out;
            out_b_ff <= ~nxt_out;
        end
    end

    assign first_output_a = out_a_ff;
    assign first_output_b = out_b_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_low_done;
        state_ff == ST_LOW && src_rise && cnt_ff == low_cnt;
    endsequence

    sequence s_high_done;
        state_ff == ST_HIGH && src_rise && cnt_ff == high_cnt;
    endsequence

    sequence s_run_ok;
        !bypass_bit && !hold_req;
    endsequence

    a_low_to_high: assert property ( // RULE1
        (s_low_done and s_run_ok) |=> state_ff == ST_HIGH && cnt_ff == CNT_ZERO)
        else $error("low phase did not end on its count");

    a_high_to_low: assert property ( // RULE2
        (s_high_done and s_run_ok) |=> state_ff == ST_LOW && cnt_ff == CNT_ZERO)
        else $error("high phase did not end on its count");

    a_phase_stays: assert property ( // RULE13
        (state_ff == ST_LOW && src_rise && cnt_ff != low_cnt and s_run_ok)
        |=> state_ff == ST_LOW && cnt_ff == $past(cnt_ff) + CNT_ONE)
        else $error("low phase ended early");

    // output follows the source one cycle late once the state is parked
    a_bypass_path: assert property ( // RULE3
        (bypass_bit && state_ff == ST_BYPASS && !dir_active)
        |=> state_ff == ST_BYPASS && out_a_ff == $past(src_clk_lvl))
        else $error("bypass did not pass the input clock");

    a_sync_hold: assert property ( // RULE5
        (hold_req && !bypass_bit) |=> state_ff == ST_HOLD)
        else $error("obeyed sync did not hold the divider");

    a_nosync_run: assert property ( // RULE5
        (nosync_bit && !bypass_bit && state_ff == ST_HOLD) |=> state_ff != ST_HOLD)
        else $error("ignored sync still held the divider");

    a_force_level: assert property ( // RULE6
        (force_act && !dir_active) |=> out_a_ff == 1'b1)
        else $error("forced level not on the output");

    a_force_masked: assert property ( // RULE7
        (bypass_bit && force_bit && nosync_bit && !dir_active && state_ff == ST_BYPASS)
        |=> out_a_ff == $past(src_clk_lvl))
        else $error("force acted while bypassed");

    a_start_level: assert property ( // RULE9
        (state_ff == ST_HOLD && !force_act && !dir_active)
        |=> out_a_ff == $past(start_bit))
        else $error("hold level differs from start bit");

    a_offset_delay: assert property ( // RULE11
        (state_ff == ST_HOLD && phase_ofs != CNT_ZERO and s_run_ok)
        |=> state_ff == ST_DELAY)
        else $error("phase offset did not delay the start");

    a_sync_release: assert property ( // RULE14
        (state_ff == ST_HOLD && phase_ofs == CNT_ZERO and s_run_ok)
        |=> state_ff == ($past(start_bit) ? ST_HIGH : ST_LOW) && cnt_ff == CNT_ZERO)
        else $error("restart did not begin at the start phase");

    a_direct_vco: assert property ( // RULE12
        (direct_bit && src_sel == SRC_SEL_VCO) |=> out_a_ff == $past(vco_lvl))
        else $error("direct route did not pass the vco");

    a_pair_complement: assert property (
        out_b_ff == !out_a_ff)
        else $error("output pair not complementary");

endmodule : ccdiv_top
`default_nettype wire

/* File: test_channel_clock_divider.sv */
/*
 * self-checking testbench for the channel clock divider: register port,
 * bypass, division counts, forcing, chip sync and the direct route.
 * assumes ccdiv_pkg and ccdiv_top are compiled first; no partner model.
 */
`timescale 1ns/1ps
`default_nettype none
module test_channel_clock_divider
    import ccdiv_pkg::*;
;
    logic               mclk;
    logic               sys_rst;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [DATA_W-1:0]  reg_rdata;
    logic               sync_n;
    logic [1:0]         src_sel;
    logic               src_clk_lvl;
    logic               vco_lvl;
    logic               ext_clk_lvl;
    logic               first_output_a;
    logic               first_output_b;
    logic [1:0]         src_div;
    int                 errors = 0;
    int                 check_count = 0;
    int                 cyc = 0;
    int                 n_low = 0;
    logic [7:0]         cnts [4] = '{8'h00, 8'h10, 8'h03, 8'hF2};

    ccdiv_top uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_n(sync_n), .src_sel(src_sel), .src_clk_lvl(src_clk_lvl), .vco_lvl(vco_lvl),
        .ext_clk_lvl(ext_clk_lvl), .first_output_a(first_output_a),
        .first_output_b(first_output_b));

    // ----------------------------------------------------------------
    // clocks and timeout
    // ----------------------------------------------------------------
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    // divider input toggles every 2 mclk, so rises are 4 mclk apart
    always @(posedge mclk) begin
        src_div <= src_div + 2'h1;
        if (src_div[0]) src_clk_lvl <= ~src_clk_lvl;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            $display("MISMATCH at %0t: timeout", $time);
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, exp, "read data");
    endtask : reg_read

    // output must copy the input one mclk late, pair complementary
    task automatic follow(input int n);
        logic prev;
        @(negedge mclk);
        prev = src_clk_lvl;
        repeat (n) begin
            @(negedge mclk);
            check({7'h0, first_output_a}, {7'h0, prev}, "bypass copy");
            check({7'h0, first_output_b}, {7'h0, ~first_output_a}, "pair");
            prev = src_clk_lvl;
        end
    endtask : follow

    task automatic hold(input int n, input logic lvl);
        repeat (n) begin
            @(negedge mclk);
            check({7'h0, first_output_a}, {7'h0, lvl}, "static level");
        end
    endtask : hold

    // one full high and low phase, in mclk (4 per input cycle)
    task automatic measure(input logic [3:0] lo, input logic [3:0] hi);
        int n;
        n = 0;
        @(negedge mclk);
        while (first_output_a !== 1'b0 && n < 200) begin @(negedge mclk); n++; end
        while (first_output_a !== 1'b1 && n < 400) begin @(negedge mclk); n++; end
        n = 0;
        while (first_output_a === 1'b1 && n < 200) begin @(negedge mclk); n++; end
        check(8'(n), 8'((hi + 1) * 4), "high time");
        n = 0;
        while (first_output_a === 1'b0 && n < 200) begin @(negedge mclk); n++; end
        check(8'(n), 8'((lo + 1) * 4), "low time");
    endtask : measure

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
        sync_n = 1'b1; src_sel = 2'b01; src_clk_lvl = 1'b0; vco_lvl = 1'b0;
        ext_clk_lvl = 1'b0; src_div = 2'h0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        reg_read(OFS_CYCLE_COUNTS, 8'h00);    // counts clear
        reg_read(OFS_CONTROL, 8'h80);         // control
        reg_read(OFS_ROUTING, 8'h00);         // routing clear
        reg_read(10'h3FF, 8'h00);             // unmapped reads zero
        follow(20);                           // bypass copy
        $display("test reset and bypass done");
        // each of the four count pairs: boundary zero, and mixed values
        foreach (cnts[i]) begin
            reg_write(OFS_CYCLE_COUNTS, cnts[i]);
            reg_write(OFS_CONTROL, 8'h00);
            measure(cnts[i][7:4], cnts[i][3:0]); // phase lengths
        end
        $display("test division done");
        reg_write(OFS_CYCLE_COUNTS, 8'h11);
        reg_write(OFS_CONTROL, 8'hE0);
        // the divider parks one cycle after the write, and the copy shows one cycle later
        repeat (2) @(negedge mclk);
        follow(20);                           // force ignored in bypass
        reg_write(OFS_CONTROL, 8'h60);
        repeat (4) @(negedge mclk);
        hold(30, 1'b1);                       // forced high
        $display("test forcing done");
        // sync held: start level shown, restart on release
        for (int s = 0; s < 2; s++) begin
            reg_write(OFS_CONTROL, (s == 1) ? 8'h10 : 8'h00);
            @(posedge mclk) sync_n <= 1'b0;
            repeat (6) @(negedge mclk);
            hold(20, s[0]);                   // held start level
            @(posedge mclk) sync_n <= 1'b1;
            measure(4'h1, 4'h1);              // runs after release
        end
        // ignore-sync set while held: the divider must leave the hold
        @(posedge mclk) sync_n <= 1'b0;
        repeat (6) @(negedge mclk);
        reg_write(OFS_CONTROL, 8'h50);
        measure(4'h1, 4'h1);                  // sync ignored
        // offset of two rises before the low phase of two rises
        reg_write(OFS_CONTROL, 8'h02);
        repeat (6) @(posedge mclk);
        sync_n <= 1'b1;
        @(negedge mclk);
        while (first_output_a === 1'b0 && n_low < 40) begin
            @(negedge mclk);
            n_low++;
        end
        check({7'h0, n_low >= 17 && n_low <= 20}, 8'h01, "offset delay"); // delayed start
        $display("test sync done");
        // direct route: vco, ext clock, then the no-effect code
        reg_write(OFS_CONTROL, 8'h80);
        @(posedge mclk) begin vco_lvl <= 1'b1; src_sel <= 2'b10; end
        reg_write(OFS_ROUTING, 8'h02);
        reg_read(OFS_ROUTING, 8'h02);         // routing readback
        repeat (4) @(negedge mclk);
        hold(10, 1'b1);                       // vco routed
        @(posedge mclk) src_sel <= 2'b00;
        repeat (4) @(negedge mclk);
        hold(10, 1'b0);                       // ext clock routed
        @(posedge mclk) begin ext_clk_lvl <= 1'b1; src_sel <= 2'b01; end
        repeat (4) @(negedge mclk);
        follow(20);                           // code 01 no effect
        $display("test direct route done");
        end_of_test();
    end

endmodule : test_channel_clock_divider
`default_nettype wire
